// file: verilog/sgs_consts.vh
`ifndef SGS_CONSTS_VH
`define SGS_CONSTS_VH
// Control register addresses (plain register port, one word per address).
`define SGS_ADDR_CTRL1      4'h1
`define SGS_ADDR_CTRL_A     4'h0a
`define SGS_ADDR_CTRL_B     4'h0b
`define SGS_ADDR_MODE1      4'h2
`define SGS_ADDR_MODE2      4'h3
`define SGS_ADDR_SYS14      4'h4
`define SGS_ADDR_SYS15      4'h5
`define SGS_ADDR_SPECIAL_VERTICAL_TIMING_V12   4'h6
`define SGS_ADDR_SPECIAL_VERTICAL_TIMING_V34   4'h7
`define SGS_ADDR_STATUS     4'h8
// Field positions.
`define SGS_C1_MULTI        0
`define SGS_C1_SUPPRESS     1
`define SGS_CA_COMBINE_LO   0
`define SGS_CA_SPECIAL_VERTICAL_ENABLE      4
`define SGS_CB_COUNT_LO     0
`define SGS_CB_OUT_EN       11
`define SGS_CB_HS_LO        12
`define SGS_M1_LINE_LO      0
`define SGS_M2_SET_SEL      0
`define SGS_SYS_FALL_LO     0
`define SGS_SYS_RISE_LO     9
`define SGS_SPECIAL_VERTICAL_TIMING_START_LO   0
`define SGS_SPECIAL_VERTICAL_TIMING_END_LO     13
// Reset values.
`define SGS_RST_WORD        32'h0000_0000
// Spacing between extra high speed pulses, in overlap-counter pixels.
`define SGS_HS_STEP         9'h020
`define SGS_HS_WIDTH        9'h008
`endif

// file: verilog/sgs_shutter_special_vertical_timing.v
// Behaviour
// - Special vertical timing is produced only in the sensor gate line.
// - Four combine bits pick OR (0) or AND (1) per vertical phase.
// - AND phase: special timing starts high, falls at start toggle.
// - OR phase: special timing starts low, rises at start toggle.
// - Special toggle positions compare against the 13-bit line pixel counter.
// - Normal mode: at most one shutter pulse per line, count 0-2047 per field.
// - Shutter pulses begin on the line after the sensor gate line.
// - Suppress bit set omits the first shutter pulse after the gate line.
// - Shutter pulse idles high, falls at first toggle, rises at second.
// - Two sets of 9-bit toggle positions compared with the overlap counter.
// - Set select 0 picks set one, 1 picks set two.
// - Output enable 0 disables the substrate clock output, 1 enables.
// - Single mode, count n: one extra pulse at predefined position n.
// - Multiple mode, count n: n extra sequential pulses in the line.
// - High speed count zero adds no extra pulses.
// - Special vertical enable 0 disables, 1 enables the feature.
// - Seven-bit gate active line; line pixel counter starts there.
`timescale 1ns/1ps
`default_nettype none
`include "sgs_consts.vh"
module sgs_shutter_special_vertical_timing (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst,
  // Register port.
  input  wire        reg_wr,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  // Timing references.
  input  wire        line_sync,
  input  wire        field_sync,
  input  wire [8:0]  overlap_pixel_counter,
  // Vertical phases from the normal sequencer, bit 0 is phase one.
  input  wire [3:0]  vertical_in,
  // Outputs.
  output reg  [3:0]  vertical_out,
  output reg         substrate_clock
);

  ////////////////////////////////////////////////////////////////////////////
  // Control fields, written through the register port.
  reg        multi_r;
  reg        suppress_r;
  reg [3:0]  combine_r;
  reg        special_vertical_enable_r;
  reg [10:0] count_cfg_r;
  reg        out_en_r;
  reg [2:0]  hs_cnt_r;
  reg [6:0]  gate_line_r;
  reg        set_sel_r;
  reg [8:0]  set_one_fall_r;
  reg [8:0]  set_one_rise_r;
  reg [8:0]  set_two_fall_r;
  reg [8:0]  set_two_rise_r;
  // Toggle pairs are shared by phases one and two, and by three and four.
  reg [12:0] toggle_start_v12_r;
  reg [12:0] toggle_end_v12_r;
  reg [12:0] toggle_start_v34_r;
  reg [12:0] toggle_end_v34_r;

  always @(posedge clk) begin
    if (rst) begin
      multi_r            <= 1'b0;
      suppress_r         <= 1'b0;
      combine_r          <= 4'h0;
      special_vertical_enable_r          <= 1'b0;
      count_cfg_r        <= 11'h000;
      out_en_r           <= 1'b0;
      hs_cnt_r           <= 3'h0;
      gate_line_r        <= 7'h00;
      set_sel_r          <= 1'b0;
      set_one_fall_r     <= 9'h000;
      set_one_rise_r     <= 9'h000;
      set_two_fall_r     <= 9'h000;
      set_two_rise_r     <= 9'h000;
      toggle_start_v12_r <= 13'h0000;
      toggle_end_v12_r   <= 13'h0000;
      toggle_start_v34_r <= 13'h0000;
      toggle_end_v34_r   <= 13'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `SGS_ADDR_CTRL1: begin
          multi_r    <= reg_wdata[`SGS_C1_MULTI];
          suppress_r <= reg_wdata[`SGS_C1_SUPPRESS];
        end
        `SGS_ADDR_CTRL_A: begin
          combine_r <= reg_wdata[`SGS_CA_COMBINE_LO +: 4];
          special_vertical_enable_r <= reg_wdata[`SGS_CA_SPECIAL_VERTICAL_ENABLE];
        end
        `SGS_ADDR_CTRL_B: begin
          count_cfg_r <= reg_wdata[`SGS_CB_COUNT_LO +: 11];
          out_en_r    <= reg_wdata[`SGS_CB_OUT_EN];
          hs_cnt_r    <= reg_wdata[`SGS_CB_HS_LO +: 3];
        end
        `SGS_ADDR_MODE1: begin
          gate_line_r <= reg_wdata[`SGS_M1_LINE_LO +: 7];
        end
        `SGS_ADDR_MODE2: begin
          set_sel_r <= reg_wdata[`SGS_M2_SET_SEL];
        end
        `SGS_ADDR_SYS14: begin
          set_one_fall_r <= reg_wdata[`SGS_SYS_FALL_LO +: 9];
          set_one_rise_r <= reg_wdata[`SGS_SYS_RISE_LO +: 9];
        end
        `SGS_ADDR_SYS15: begin
          set_two_fall_r <= reg_wdata[`SGS_SYS_FALL_LO +: 9];
          set_two_rise_r <= reg_wdata[`SGS_SYS_RISE_LO +: 9];
        end
        `SGS_ADDR_SPECIAL_VERTICAL_TIMING_V12: begin
          toggle_start_v12_r <= reg_wdata[`SGS_SPECIAL_VERTICAL_TIMING_START_LO +: 13];
          toggle_end_v12_r   <= reg_wdata[`SGS_SPECIAL_VERTICAL_TIMING_END_LO +: 13];
        end
        `SGS_ADDR_SPECIAL_VERTICAL_TIMING_V34: begin
          toggle_start_v34_r <= reg_wdata[`SGS_SPECIAL_VERTICAL_TIMING_START_LO +: 13];
          toggle_end_v34_r   <= reg_wdata[`SGS_SPECIAL_VERTICAL_TIMING_END_LO +: 13];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line and field bookkeeping.
  // Edge positions of the selected set; both sets stay programmed so a
  // switch between them needs only the select bit.
  wire [8:0] fall_pos = set_sel_r ? set_two_fall_r : set_one_fall_r;
  wire [8:0] rise_pos = set_sel_r ? set_two_rise_r : set_one_rise_r;

  reg [6:0]  line_r;
  reg [12:0] line_pix_r;
  reg        in_gate_line_r;
  reg        after_gate_r;
  reg        skip_line_r;
  reg [10:0] field_left_r;
  reg        line_fired_r;
  wire       line_last   = (line_r == 7'h7f);
  wire [6:0] line_inc    = line_r + 7'h01;
  wire       rise_here   = (overlap_pixel_counter == rise_pos);
  wire       pulses_left = (field_left_r != 11'h000);

  always @(posedge clk) begin
    if (rst) begin
      line_r         <= 7'h00;
      line_pix_r     <= 13'h0000;
      in_gate_line_r <= 1'b0;
      after_gate_r   <= 1'b0;
      skip_line_r    <= 1'b0;
      field_left_r   <= 11'h000;
      line_fired_r   <= 1'b0;
    end else if (field_sync) begin
      // The stretch from the field sync to the first line sync is line zero.
      line_r         <= 7'h00;
      line_pix_r     <= 13'h0000;
      in_gate_line_r <= (gate_line_r == 7'h00);
      after_gate_r   <= 1'b0;
      skip_line_r    <= 1'b0;
      field_left_r   <= count_cfg_r;
      line_fired_r   <= 1'b0;
    end else if (line_sync) begin
      // The line count saturates so a long field cannot wrap onto the gate line.
      line_r         <= line_last ? line_r : line_inc;
      in_gate_line_r <= !line_last && (line_inc == gate_line_r);
      line_pix_r     <= 13'h0000;
      if (in_gate_line_r) begin
        after_gate_r <= 1'b1;
      end
      // Only the line right after the gate line can be swallowed.
      skip_line_r    <= in_gate_line_r && suppress_r;
      line_fired_r   <= 1'b0;
    end else begin
      line_pix_r <= line_pix_r + 13'h0001;
      // The field count is spent at the rise, also for a swallowed pulse.
      if (after_gate_r && !line_fired_r && pulses_left && rise_here) begin
        line_fired_r <= 1'b1;
        field_left_r <= field_left_r - 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Substrate clock shaping.
  // Half open window: a pulse lets go on its end position.
  function in_win;
    input [8:0] pos;
    input [8:0] lo;
    input [8:0] hi;
    begin
      in_win = (pos >= lo) && (pos < hi);
    end
  endfunction

  // Start of extra pulse idx; it sits idx steps after the normal rise.
  function [8:0] extra_base;
    input [8:0] rise;
    input [2:0] idx;
    begin
      extra_base = rise + ({6'h00, idx} * `SGS_HS_STEP);
    end
  endfunction

  // Multiple mode keeps positions 1 to n, single mode only position n.
  function extra_used;
    input       multi;
    input [2:0] cnt;
    input [2:0] idx;
    begin
      if (multi) begin
        extra_used = (idx <= cnt);
      end else begin
        extra_used = (idx == cnt);
      end
    end
  endfunction

  // True while the pixel sits inside the window of extra pulse idx.
  function extra_hit;
    input [8:0] pix;
    input [8:0] rise;
    input [2:0] idx;
    reg   [8:0] lo;
    begin
      lo        = extra_base(rise, idx);
      extra_hit = in_win(pix, lo, lo + `SGS_HS_WIDTH);
    end
  endfunction

  // Positions wrap at the end of the overlap count; the user keeps the last
  // wanted position inside the line.
  wire [7:1] extra_on;
  assign extra_on[1] = extra_used(multi_r, hs_cnt_r, 3'h1) &&
                       extra_hit(overlap_pixel_counter, rise_pos, 3'h1);
  assign extra_on[2] = extra_used(multi_r, hs_cnt_r, 3'h2) &&
                       extra_hit(overlap_pixel_counter, rise_pos, 3'h2);
  assign extra_on[3] = extra_used(multi_r, hs_cnt_r, 3'h3) &&
                       extra_hit(overlap_pixel_counter, rise_pos, 3'h3);
  assign extra_on[4] = extra_used(multi_r, hs_cnt_r, 3'h4) &&
                       extra_hit(overlap_pixel_counter, rise_pos, 3'h4);
  assign extra_on[5] = extra_used(multi_r, hs_cnt_r, 3'h5) &&
                       extra_hit(overlap_pixel_counter, rise_pos, 3'h5);
  assign extra_on[6] = extra_used(multi_r, hs_cnt_r, 3'h6) &&
                       extra_hit(overlap_pixel_counter, rise_pos, 3'h6);
  assign extra_on[7] = extra_used(multi_r, hs_cnt_r, 3'h7) &&
                       extra_hit(overlap_pixel_counter, rise_pos, 3'h7);
  wire extra_low = |extra_on;

  // A swallowed line drops its extras too, so that line carries no shutter.
  wire shutter_line = after_gate_r && !skip_line_r;
  wire line_ok      = shutter_line && pulses_left && !line_fired_r;
  wire extra_ok     = shutter_line && line_fired_r;
  wire main_low     = line_ok && in_win(overlap_pixel_counter, fall_pos, rise_pos);
  wire sub_nxt      = out_en_r ? !(main_low || (extra_ok && extra_low)) : 1'b1;

  // Status word: where the field stands and how many pulses remain.
  wire [31:0] status_word = {19'h00000, after_gate_r, in_gate_line_r, field_left_r};

  ////////////////////////////////////////////////////////////////////////////
  // Special vertical timing per phase.
  // Level of the internal special timing: an AND phase rests high and an
  // OR phase rests low, each flipping between the start and end toggles.
  function special_vertical_timing_level;
    input        and_mode;
    input [12:0] pix;
    input [12:0] start_pos;
    input [12:0] end_pos;
    begin
      if (pix >= start_pos && pix < end_pos) begin
        special_vertical_timing_level = !and_mode;
      end else begin
        special_vertical_timing_level = and_mode;
      end
    end
  endfunction

  // Merge of one phase with its special timing, by the phase's combine bit.
  function merge_phase;
    input and_mode;
    input vin;
    input special_vertical_timing;
    begin
      if (and_mode) begin
        merge_phase = vin & special_vertical_timing;
      end else begin
        merge_phase = vin | special_vertical_timing;
      end
    end
  endfunction

  wire       special_vertical_timing_live = special_vertical_enable_r && in_gate_line_r;
  wire [3:0] special_vertical_timing_sig;
  wire [3:0] vert_merged;
  wire [3:0] vert_nxt;

  assign special_vertical_timing_sig[0] = special_vertical_timing_level(combine_r[0], line_pix_r,
                                  toggle_start_v12_r, toggle_end_v12_r);
  assign special_vertical_timing_sig[1] = special_vertical_timing_level(combine_r[1], line_pix_r,
                                  toggle_start_v12_r, toggle_end_v12_r);
  assign special_vertical_timing_sig[2] = special_vertical_timing_level(combine_r[2], line_pix_r,
                                  toggle_start_v34_r, toggle_end_v34_r);
  assign special_vertical_timing_sig[3] = special_vertical_timing_level(combine_r[3], line_pix_r,
                                  toggle_start_v34_r, toggle_end_v34_r);

  assign vert_merged[0] = merge_phase(combine_r[0],
                                      vertical_in[0], special_vertical_timing_sig[0]);
  assign vert_merged[1] = merge_phase(combine_r[1],
                                      vertical_in[1], special_vertical_timing_sig[1]);
  assign vert_merged[2] = merge_phase(combine_r[2],
                                      vertical_in[2], special_vertical_timing_sig[2]);
  assign vert_merged[3] = merge_phase(combine_r[3],
                                      vertical_in[3], special_vertical_timing_sig[3]);

  // Outside the gate line, or with the feature off, the phases pass untouched.
  assign vert_nxt = special_vertical_timing_live ? vert_merged : vertical_in;

  // Every output leaves from a flip-flop so the drivers see no decode glitches.
  always @(posedge clk) begin
    if (rst) begin
      vertical_out <= 4'h0;
    end else begin
      vertical_out <= vert_nxt;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      substrate_clock <= 1'b1;
    end else begin
      substrate_clock <= sub_nxt;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `SGS_RST_WORD;
    end else begin
      reg_rdata <= status_word;
    end
  end

endmodule // sgs_shutter_special_vertical_timing
`default_nettype wire

// file: dv/sgs_shutter_special_vertical_timing_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sgs_shutter_special_vertical_timing_assertions (
  // Clock and register port.
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Timing, phases and shutter.
  input wire logic        line_sync,
  input wire logic        field_sync,
  input wire logic [8:0]  overlap_pixel_counter,
  input wire logic [3:0]  vertical_in,
  input wire logic [3:0]  vertical_out,
  input wire logic        substrate_clock
);
  logic [17:0] s1_r, s2_r, pos;
  logic [10:0] cnt_r;
  logic [2:0]  hs_r, nf_r;
  logic        sel_r, en_r, spe_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff rst;
  assign pos = sel_r ? s2_r : s1_r;
  // Shadow copies of the written fields, so edges can be tied to their settings.
  always_ff @(posedge clk) begin
    if (rst) begin
      {s1_r, s2_r, cnt_r, hs_r, sel_r, en_r, spe_r} <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        4'h3: sel_r <= reg_wdata[0];
        4'h4: s1_r <= reg_wdata[17:0];
        4'h5: s2_r <= reg_wdata[17:0];
        4'ha: spe_r <= reg_wdata[4];
        4'hb: {hs_r, en_r, cnt_r} <= reg_wdata[14:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk) nf_r <= (rst || line_sync) ? 3'h0 : nf_r + {2'h0, $fell(substrate_clock)};
  ////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property ($fell(rst) |-> substrate_clock && vertical_out == 4'h0 && reg_rdata == 32'h0)
    else $error("outputs not idle after reset");
  a_output_gated: assert property (!en_r && !$past(en_r) |-> substrate_clock)
    else $error("substrate clock pulsed while disabled");
  a_special_vertical_timing_bypass: assert property (!spe_r && !$past(spe_r) && !$past(rst) |-> vertical_out == $past(vertical_in))
    else $error("vertical phases altered while special timing off");
  a_fall_position: assert property ($fell(substrate_clock) && hs_r == 3'h0 |-> $past(overlap_pixel_counter) == pos[8:0])
    else $error("substrate clock fell at wrong pixel");
  a_rise_position: assert property ($rose(substrate_clock) && hs_r == 3'h0 |-> $past(overlap_pixel_counter) == pos[17:9])
    else $error("substrate clock rose at wrong pixel");
  a_one_per_line: assert property (hs_r == 3'h0 |-> nf_r <= 3'h1)
    else $error("more than one shutter pulse in a line");
  a_outside_gate: assert property (!reg_rdata[11] && !$past(reg_rdata[11]) && !$past(rst) |-> vertical_out == $past(vertical_in))
    else $error("special timing outside the gate line");
  a_field_reload: assert property (field_sync |-> ##2 reg_rdata[10:0] == cnt_r)
    else $error("pulse counter not reloaded at field start");
endmodule // sgs_shutter_special_vertical_timing_assertions
bind sgs_shutter_special_vertical_timing sgs_shutter_special_vertical_timing_assertions i_sgs_shutter_special_vertical_timing_assertions (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_sync(line_sync),
  .field_sync(field_sync), .overlap_pixel_counter(overlap_pixel_counter), .vertical_in(vertical_in),
  .vertical_out(vertical_out), .substrate_clock(substrate_clock));
`default_nettype wire

// file: dv/sgs_ccd_model.sv
`timescale 1ns/1ps
`default_nettype none
module sgs_ccd_model (
  // Sensor drive inputs.
  input  wire logic       clk,
  input  wire logic       line_sync,
  input  wire logic       substrate_clock,
  // Shutter pulses seen in the last whole line.
  output var  logic [3:0] line_pulses
);
  logic [3:0] run_r;
  logic       sub_r;
  // The sensor clears charge on each falling substrate edge.
  always @(posedge clk) begin
    sub_r <= substrate_clock;
    run_r <= line_sync ? 4'h0 : run_r + {3'h0, sub_r & ~substrate_clock};
    if (line_sync) line_pulses <= run_r;
  end
endmodule // sgs_ccd_model
`default_nettype wire

// file: dv/tb_sgs_shutter_special_vertical_timing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sgs_shutter_special_vertical_timing;
  logic        clk = 0, rst = 1, reg_wr = 0, line_sync = 0, field_sync = 0, substrate_clock;
  logic [3:0]  reg_addr = 0, vertical_in = 0, vertical_out, line_pulses;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [8:0]  px = 0;
  logic [31:0] q[$];
  logic [6:0]  cases[8] = '{7'h00, 7'h40, 7'h41, 7'h42, 7'h58, 7'h78, 7'h4c, 7'h7c};
  int          num_errors = 0, compares = 0;
  bit          seen = 0;
  sgs_shutter_special_vertical_timing i_sgs_shutter_special_vertical_timing (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_sync(line_sync), .field_sync(field_sync),
    .overlap_pixel_counter(px), .vertical_in(vertical_in), .vertical_out(vertical_out), .substrate_clock(substrate_clock));
  sgs_ccd_model i_sgs_ccd_model (.clk(clk), .line_sync(line_sync), .substrate_clock(substrate_clock),
    .line_pulses(line_pulses));
  initial forever #4 clk = ~clk;
  always @(posedge clk) vertical_in <= 4'($urandom);
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Case word: en, hs count[2:0], multi, suppress, set select. Special_vertical_timing follows en.
  task automatic field(input logic [6:0] c);
    int g, n, last;
    logic [3:0] comb;
    g = 1 + $urandom % 3;
    n = 1 + $urandom % 3;
    comb = 4'($urandom);
    last = g + n + 2 - c[1];
    wr(4'h1, {30'h0, c[1], c[2]});
    // The stretch before the first line sync is line zero, so bench line g is g + 1.
    wr(4'h2, g + 1);
    wr(4'h3, {31'h0, c[0]});
    wr(4'ha, {27'h0, c[6], comb});
    wr(4'hb, {17'h0, c[5:3], c[6], n[10:0]});
    wr(4'hf, $urandom);
    for (int i = 0; i < last; i++)
      q.push_back((i > g && i <= g + n && c[6] && !(c[1] && i == g + 1)) ? 1 + (c[5:3] == 0 ? 0 : c[2] ? c[5:3] : 1) : 0);
    @(posedge clk) field_sync <= 1'b1;
    @(posedge clk) field_sync <= 1'b0;
    for (int i = 0; i < last; i++)
      for (int p = 0; p < 360; p++) begin
        @(posedge clk);
        line_sync <= (p == 0);
        px <= p[8:0];
        if (i == g && p == 176 && c[6]) #1 check({28'h0, vertical_out}, {28'h0, ~comb}, "vertical_out");
      end
  endtask
  // Pulses of a line are known only once the next line has started.
  always @(posedge clk) begin
    if (line_sync) begin
      #1 if (seen && q.size() > 0) check({28'h0, line_pulses}, q.pop_front(), "line_pulses");
      seen = 1;
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hc2aa2f9a));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check(reg_rdata, 32'h0, "reg_rdata");
    wr(4'h4, {14'h0, 9'h03c, 9'h028});
    wr(4'h5, {14'h0, 9'h078, 9'h064});
    wr(4'h6, {6'h0, 13'h00c8, 13'h0096});
    wr(4'h7, {6'h0, 13'h00c8, 13'h0096});
    foreach (cases[k]) begin
      field(cases[k]);
      $display("test %0d done", k);
    end
    tally_and_finish();
  end
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
endmodule // tb_sgs_shutter_special_vertical_timing
`default_nettype wire
